// >>> shared/adct_consts.vh
// constants for the converter sequencing and trigger timer block
`ifndef ADCT_CONSTS_VH
`define ADCT_CONSTS_VH
`define ADCT_CHANNELS 16
`define ADCT_TMR_WIDTH 24
`define ADCT_PERIOD_RST 24'hffffff
// command word layout
`define ADCT_CMD_CHAN_LSB 0
`define ADCT_CMD_CHAN_MSB 3
`define ADCT_CMD_RES8_BIT 4
`define ADCT_CMD_CONT_BIT 5
`define ADCT_CMD_LEN_LSB 8
`define ADCT_CMD_LEN_MSB 11
// trigger source select codes
`define ADCT_TRG_SOFT 2'h0
`define ADCT_TRG_EXT 2'h1
`define ADCT_TRG_SYS0 2'h2
`define ADCT_TRG_SYS1 2'h3
`define ADCT_RES_RST 10'h000
`endif

// >>> rtl/adct_top.v
// converter sequencing, command decode and the two internal trigger down-counters
`timescale 1ns/1ps
`include "adct_consts.vh"
module adct_top #(
	parameter TW = `ADCT_TMR_WIDTH,
	parameter NCH = `ADCT_CHANNELS
) (
	input wire clock, // system clock
	input wire rst, // async reset, high
	input wire [TW-1:0] period0, // period of counter zero
	input wire [TW-1:0] period1, // period of counter one
	input wire load0, // pulse: load period0 now
	input wire load1, // pulse: load period1 now
	input wire tmrEn0, // counter zero runs
	input wire tmrEn1, // counter one runs
	output wire [TW-1:0] count0, // live count zero
	output wire [TW-1:0] count1, // live count one
	output wire trigLineZero, // internal trigger pulse zero
	output wire trigLineOne, // internal trigger pulse one
	input wire [1:0] trigSelA, // trigger source, first converter
	input wire [1:0] trigSelB, // trigger source, second converter
	input wire [3:0] extPinSelA, // trigger pin, first converter
	input wire [3:0] extPinSelB, // trigger pin, second converter
	input wire [NCH-1:0] anaPinA, // digital view of analog pins, first
	input wire [NCH-1:0] anaPinB, // digital view of analog pins, second
	input wire [15:0] cmdDataA, // command word, first
	input wire cmdValidA, // command write strobe, first
	output wire cmdReqA, // wants next command, first
	output wire [9:0] resDataA, // result, first
	output wire resReqA, // result ready, first
	input wire resAckA, // result read, first
	output wire [3:0] muxSelA, // analog input selected, first
	output wire sampleA, // sample strobe to analog core, first
	input wire [9:0] sarValA, // raw analog core value, first
	input wire sarDoneA, // analog core finished, first
	input wire [15:0] cmdDataB, // command word, second
	input wire cmdValidB, // command write strobe, second
	output wire cmdReqB, // wants next command, second
	output wire [9:0] resDataB, // result, second
	output wire resReqB, // result ready, second
	input wire resAckB, // result read, second
	output wire [3:0] muxSelB, // analog input selected, second
	output wire sampleB, // sample strobe, second
	input wire [9:0] sarValB, // raw core value, second
	input wire sarDoneB // core finished, second
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_CONV = 2'h2;
	localparam ST_HOLD = 2'h3;

	reg [TW-1:0] cnt0_r, cnt1_r;
	reg fire0_r, fire1_r;

	// reload at zero without a lost cycle; the count reads as zero for one clock
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt0_r <= `ADCT_PERIOD_RST;
			cnt1_r <= `ADCT_PERIOD_RST;
			fire0_r <= 1'b0;
			fire1_r <= 1'b0;
		end else begin
			fire0_r <= tmrEn0 && !load0 && (cnt0_r == {TW{1'b0}});
			fire1_r <= tmrEn1 && !load1 && (cnt1_r == {TW{1'b0}});
			if (load0)
				cnt0_r <= period0;
			else if (tmrEn0)
				cnt0_r <= (cnt0_r == {TW{1'b0}}) ? period0 : cnt0_r - 1'b1;
			if (load1)
				cnt1_r <= period1;
			else if (tmrEn1)
				cnt1_r <= (cnt1_r == {TW{1'b0}}) ? period1 : cnt1_r - 1'b1;
		end
	end
	assign count0 = cnt0_r;
	assign count1 = cnt1_r;
	assign trigLineZero = fire0_r;
	assign trigLineOne = fire1_r;

	// both converters see the same fire pulse in the same cycle
	reg [NCH-1:0] pinA1_r, pinA2_r, pinB1_r, pinB2_r;
	reg extA_r, extB_r;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pinA1_r <= {NCH{1'b0}};
			pinA2_r <= {NCH{1'b0}};
			pinB1_r <= {NCH{1'b0}};
			pinB2_r <= {NCH{1'b0}};
			extA_r <= 1'b0;
			extB_r <= 1'b0;
		end else begin
			pinA1_r <= anaPinA;
			pinA2_r <= pinA1_r;
			pinB1_r <= anaPinB;
			pinB2_r <= pinB1_r;
			extA_r <= pinA2_r[extPinSelA];
			extB_r <= pinB2_r[extPinSelB];
		end
	end
	wire extRiseA = pinA2_r[extPinSelA] && !extA_r;
	wire extRiseB = pinB2_r[extPinSelB] && !extB_r;

	function startSel;
		input [1:0] sel;
		input ext, t0, t1;
		begin
			case (sel)
				`ADCT_TRG_SOFT: startSel = 1'b1;
				`ADCT_TRG_EXT: startSel = ext;
				`ADCT_TRG_SYS0: startSel = t0;
				`ADCT_TRG_SYS1: startSel = t1;
				default: startSel = 1'b0;
			endcase
		end
	endfunction
	wire startA = startSel(trigSelA, extRiseA, fire0_r, fire1_r);
	wire startB = startSel(trigSelB, extRiseB, fire0_r, fire1_r);

	// per-converter sequencer, unrolled through a generate over the two instances
	wire [1:0] cmdV = {cmdValidB, cmdValidA};
	wire [31:0] cmdD = {cmdDataB, cmdDataA};
	wire [1:0] stT = {startB, startA};
	wire [1:0] sDone = {sarDoneB, sarDoneA};
	wire [19:0] sVal = {sarValB, sarValA};
	wire [1:0] rAck = {resAckB, resAckA};
	wire [1:0] cReq, rReq, smp;
	wire [19:0] rDat;
	wire [7:0] mSel;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : conv
			reg [1:0] st_r;
			reg [15:0] cmd_r;
			reg [3:0] left_r;
			reg [9:0] res_r;
			reg rv_r, smp_r;
			wire [3:0] chan = cmd_r[`ADCT_CMD_CHAN_MSB:`ADCT_CMD_CHAN_LSB];
			wire res8 = cmd_r[`ADCT_CMD_RES8_BIT];
			wire cont = cmd_r[`ADCT_CMD_CONT_BIT];
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					st_r <= ST_IDLE;
					cmd_r <= 16'h0000;
					left_r <= 4'h0;
					res_r <= `ADCT_RES_RST;
					rv_r <= 1'b0;
					smp_r <= 1'b0;
				end else begin
					smp_r <= 1'b0;
					// a read and a new result in one cycle: new result wins
					if (rAck[g])
						rv_r <= 1'b0;
					case (st_r)
						ST_IDLE: begin
							if (cmdV[g]) begin
								cmd_r <= cmdD[16*g+15:16*g];
								left_r <= cmdD[16*g+`ADCT_CMD_LEN_MSB:16*g+`ADCT_CMD_LEN_LSB];
								st_r <= ST_WAIT;
							end
						end
						ST_WAIT: begin
							if (stT[g]) begin
								smp_r <= 1'b1;
								st_r <= ST_CONV;
							end
						end
						ST_CONV: begin
							if (sDone[g]) begin
								// eight bit mode keeps the top bits, right aligned
								res_r <= res8 ? {2'b00, sVal[10*g+9:10*g+2]} : sVal[10*g+9:10*g];
								rv_r <= 1'b1;
								st_r <= ST_HOLD;
							end
						end
						ST_HOLD: begin
							// no overwrite: wait until the last result is taken
							if (!rv_r || rAck[g]) begin
								if (left_r != 4'h0) begin
									left_r <= left_r - 4'h1;
									smp_r <= cont;
									st_r <= cont ? ST_CONV : ST_WAIT;
								end else
									st_r <= ST_IDLE;
							end
						end
						default: st_r <= ST_IDLE;
					endcase
				end
			end
			assign cReq[g] = (st_r == ST_IDLE);
			assign rReq[g] = rv_r;
			assign rDat[10*g+9:10*g] = res_r;
			assign mSel[4*g+3:4*g] = chan;
			assign smp[g] = smp_r;
		end
	endgenerate
	assign cmdReqA = cReq[0];
	assign cmdReqB = cReq[1];
	assign resReqA = rReq[0];
	assign resReqB = rReq[1];
	assign resDataA = rDat[9:0];
	assign resDataB = rDat[19:10];
	assign muxSelA = mSel[3:0];
	assign muxSelB = mSel[7:4];
	assign sampleA = smp[0];
	assign sampleB = smp[1];
endmodule // adct_top

// >>> verif/adct_sva.sv
// checks on counter zero and the first converter's handshakes
`timescale 1ns/1ps
module adct_sva #(parameter TW = 24) (
	input wire clock, // clock
	input wire rst, // reset
	input wire [TW-1:0] period0, // reload
	input wire load0, // load
	input wire tmrEn0, // run
	input wire [TW-1:0] count0, // count
	input wire trigLineZero, // trigger
	input wire cmdValidA, // strobe
	input wire cmdReqA, // idle
	input wire sampleA, // sample
	input wire sarDoneA, // done
	input wire resReqA // ready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_count_dec: assert property (tmrEn0 && !load0 && |count0
		|=> count0 == $past(count0) - 1'b1 && !trigLineZero) else $error("bad step");
	a_zero_reload: assert property (tmrEn0 && !load0 && !count0
		|=> trigLineZero && count0 == $past(period0)) else $error("no reload");
	a_count_frozen: assert property (!tmrEn0 && !load0 |=> $stable(count0))
		else $error("count moved");
	a_load_taken: assert property (load0 |=> count0 == $past(period0) && !trigLineZero)
		else $error("no load");
	a_pulse_single: assert property (trigLineZero |=> !trigLineZero)
		else $error("wide pulse");
	a_cmd_taken: assert property (cmdValidA && cmdReqA |=> !cmdReqA)
		else $error("command lost");
	a_sample_busy: assert property (sampleA |-> !cmdReqA ##1 !sampleA)
		else $error("stray sample");
	a_done_result: assert property (sarDoneA && !cmdReqA |=> resReqA)
		else $error("no result");
	c_trigger: cover property (trigLineZero);
	c_sample: cover property (sampleA);
	c_result: cover property (resReqA);
endmodule // adct_sva

// >>> verif/adct_core_model.sv
// analog core stand-in: one value per sample strobe, lag plus one clocks after the strobe is seen
`timescale 1ns/1ps
module adct_core_model (
	input wire clock, // system clock
	input wire sample, // start strobe
	input wire [3:0] muxSel, // input chosen
	input wire [3:0] lag, // clocks to answer, less one
	output reg [9:0] sarVal = 10'h0, // core value
	output reg sarDone = 1'b0 // done pulse
);
	integer n = -1;
	always @(posedge clock) begin
		sarDone <= n == 0;
		// value only valid with done, so it toggles otherwise
		sarVal <= n == 0 ? {muxSel, ~muxSel, 2'h2} : ~sarVal;
		n <= sample ? lag : n - (n >= 0);
	end
endmodule // adct_core_model

// >>> verif/adct_top_tb_top.sv
// bench: both converters in step over every trigger source
`timescale 1ns/1ps
module adct_top_tb_top;
	reg clock = 1'b0, rst = 1'b1, load0 = 1'b0, load1 = 1'b0, tmrEn0 = 1'b0, tmrEn1 = 1'b0;
	reg cmdValidA = 1'b0, resAckA = 1'b0;
	reg [23:0] period0 = 24'h0, period1 = 24'h0;
	reg [1:0] trigSelA = 2'h0;
	reg [3:0] extPinSelA = 4'h0, lag = 4'h0;
	reg [15:0] anaPinA = 16'h0, cmdDataA = 16'h0;
	reg [9:0] q[$], v, e;
	reg [3:0] ch = 4'h0;
	wire [23:0] count0, count1;
	wire [9:0] resDataA, resDataB, sarValA;
	wire [3:0] muxSelA, muxSelB;
	wire trigLineZero, trigLineOne, cmdReqA, cmdReqB, resReqA, resReqB;
	wire sampleA, sampleB, sarDoneA;
	integer errors = 0, compares = 0, seed = 32'hce010527, i, n, sa = 0, sb = 0, ns = 0;
	// both converters share every input, so they must run in step
	adct_top dut (.clock(clock), .rst(rst), .period0(period0), .period1(period1),
		.load0(load0), .load1(load1), .tmrEn0(tmrEn0), .tmrEn1(tmrEn1), .count0(count0),
		.count1(count1), .trigLineZero(trigLineZero), .trigLineOne(trigLineOne),
		.trigSelA(trigSelA), .trigSelB(trigSelA), .extPinSelA(extPinSelA),
		.extPinSelB(extPinSelA), .anaPinA(anaPinA), .anaPinB(anaPinA), .cmdDataA(cmdDataA),
		.cmdValidA(cmdValidA), .cmdReqA(cmdReqA), .resDataA(resDataA), .resReqA(resReqA),
		.resAckA(resAckA), .muxSelA(muxSelA), .sampleA(sampleA), .sarValA(sarValA),
		.sarDoneA(sarDoneA), .cmdDataB(cmdDataA), .cmdValidB(cmdValidA), .cmdReqB(cmdReqB),
		.resDataB(resDataB), .resReqB(resReqB), .resAckB(resAckA), .muxSelB(muxSelB),
		.sampleB(sampleB), .sarValB(sarValA), .sarDoneB(sarDoneA));
	adct_core_model core (.clock(clock), .sample(sampleA), .muxSel(muxSelA), .lag(lag),
		.sarVal(sarValA), .sarDone(sarDoneA));
	initial forever #10 clock = ~clock;
	task chk(input [23:0] got, exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task results;
		begin
			$display("compares %0d errors %0d", compares, errors);
			if (errors == 0 && compares > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task idle; // asks again only once its last result was read
		begin
			for (n = 0; n < 3000 && (q.size() || cmdReqA !== 1'b1); n = n + 1)
				@(posedge clock) #1;
			if (n == 3000) begin
				errors = errors + 1;
				results;
			end
		end
	endtask
	always @(posedge clock) begin
		resAckA <= #1 resReqA === 1'b1 && !resAckA;
		if (sampleA === 1'b1)
			sa = sa + 1;
		if (sampleB === 1'b1)
			sb = sb + 1;
		// the pulse cycle is also the cycle the reloaded period shows
		if (trigLineZero === 1'b1)
			chk(count0, period0);
		if (trigLineOne === 1'b1)
			chk(count1, period1);
		if (resReqA === 1'b1 && !resAckA) begin
			e = q.size() ? q.pop_front() : 10'hx;
			chk(resDataA, e);
			chk({resReqB, resDataB}, {1'b1, e});
			chk({muxSelA, muxSelB}, {ch, ch});
		end
	end
	initial begin
		repeat (2) @(posedge clock) #1;
		rst = 1'b0;
		@(posedge clock) #1 period0 = 2 + {$random(seed)} % 8;
		period1 = 2 + {$random(seed)} % 8;
		{load0, load1, tmrEn0, tmrEn1} = 4'hf;
		@(posedge clock) #1 {load0, load1} = 2'h0;
		repeat (7) @(posedge clock) #1;
		chk(count0, period0 - 7 % (period0 + 1));
		chk(count1, period1 - 7 % (period1 + 1));
		tmrEn0 = 1'b0;
		repeat (3) @(posedge clock) #1;
		chk(count0, period0 - 7 % (period0 + 1));
		tmrEn0 = 1'b1;
		$display("counter test done");
		for (i = 0; i < 4; i = i + 1) begin
			idle;
			{lag, extPinSelA} = $random(seed);
			trigSelA = i;
			cmdDataA = {4'h0, i[1] ? i[3:0] : 4'h0, 2'h0, i[0], i[0] ^ i[1], 4'h0};
			cmdDataA[3:0] = $random(seed);
			ch = cmdDataA[3:0];
			ns = cmdDataA[11:8] + 1;
			sa = 0;
			sb = 0;
			v = {cmdDataA[3:0], ~cmdDataA[3:0], 2'h2};
			for (n = 0; n <= cmdDataA[11:8]; n = n + 1)
				q.push_back(cmdDataA[4] ? v >> 2 : v);
			cmdValidA = 1'b1;
			@(posedge clock) #1 cmdDataA = 16'h0f00;
			cmdValidA = i == 2; // a second word while busy is ignored
			@(posedge clock) #1 cmdValidA = 1'b0;
			if (i == 1) begin
				anaPinA = ~(16'h1 << extPinSelA);
				repeat (24) @(posedge clock) #1;
				chk(q.size(), 1);
				anaPinA = 16'hffff;
			end
			idle;
			chk(sa, ns);
			chk({cmdReqB, sb[7:0]}, {1'b1, ns[7:0]});
			anaPinA = 16'h0;
			$display("trigger source %0d test done", i);
		end
		results;
	end
endmodule // adct_top_tb_top
bind adct_top adct_sva #(.TW(TW)) sva (.clock(clock), .rst(rst), .period0(period0),
	.load0(load0), .tmrEn0(tmrEn0), .count0(count0), .trigLineZero(trigLineZero),
	.cmdValidA(cmdValidA), .cmdReqA(cmdReqA), .sampleA(sampleA), .sarDoneA(sarDoneA),
	.resReqA(resReqA));
